/* File: dxm_pkg.sv */
// Constants, types and descriptor layout for the descriptor transfer mode engine.
// Assumes a single system clock; all users name items as dxm_pkg::name.
package dxm_pkg;

   // Transfer modes held in the first mode word
   localparam logic [1:0] MD_NORMAL = 2'h0;
   localparam logic [1:0] MD_REPEAT = 2'h1;
   localparam logic [1:0] MD_BLOCK  = 2'h2;

   // Data unit sizes, also used as bus access size
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;

   // Address update codes: 0x fixed, 10 increment, 11 decrement
   localparam logic [1:0] UPD_INC = 2'h2;
   localparam logic [1:0] UPD_DEC = 2'h3;

   // Field positions in mode_word_first
   localparam int MA_MD_HI = 7;
   localparam int MA_MD_LO = 6;
   localparam int MA_SZ_HI = 5;
   localparam int MA_SZ_LO = 4;
   localparam int MA_SU_HI = 3;
   localparam int MA_SU_LO = 2;

   // Field positions in mode_word_second
   localparam int MB_CHAIN      = 7;
   localparam int MB_CHAIN_ZERO = 6;
   localparam int MB_IRQ_SEL    = 5;
   localparam int MB_AREA       = 4;
   localparam int MB_DU_HI      = 3;
   localparam int MB_DU_LO      = 2;

   // Descriptor sizes in the data area
   localparam logic [1:0]  SHORT_LAST  = 2'h2;
   localparam logic [1:0]  FULL_LAST   = 2'h3;
   localparam logic [31:0] SHORT_BYTES = 32'h0000000C;
   localparam logic [31:0] FULL_BYTES  = 32'h00000010;

   // Software register offsets and fields
   localparam int          REG_AW     = 4;
   localparam logic [3:0]  REG_CTRL   = 4'h0;
   localparam logic [3:0]  REG_STATUS = 4'h4;
   localparam logic [3:0]  REG_DESC   = 4'h8;
   localparam logic [3:0]  REG_COUNT  = 4'hC;
   localparam int          CTRL_RCHAIN = 0;
   localparam int          CTRL_FULL   = 1;
   localparam logic [1:0]  CTRL_RST    = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_DESC_RD = 3'b001,
      ST_LOAD    = 3'b010,
      ST_DATA_RD = 3'b011,
      ST_DATA_WR = 3'b100,
      ST_UPD     = 3'b101,
      ST_WBACK   = 3'b110,
      ST_DONE    = 3'b111
   } dxm_state_e;

   // Request toward the internal bus
   typedef struct packed {
      logic        req;
      logic        we;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dxm_bus_s;

   // End-of-activation events toward CPU and interrupt controller
   typedef struct packed {
      logic irq;
      logic src_clear;
      logic en_clear;
   } dxm_evt_s;

   localparam dxm_bus_s BUS_IDLE = '0;
   localparam dxm_evt_s EVT_NONE = '0;

endpackage

/* File: dxm_engine.sv */
// Descriptor driven transfer engine: fetch, normal/repeat/block transfer, chain, writeback.
// Assumes activation, register port and bus slave run on i_sys_clk; no synchronisers needed.
// Function
// - Each activation reads descriptor, moves data, writes updated descriptor back.
// - Source pointer written back only if its select bit is 1; same for destination.
// - Pointer writeback skipping works the same in short and full formats.
// - Both transfer counts are always written back.
// - Full format never writes back the two mode words.
// - Normal mode moves one unit; count A minus one, count B kept.
// - Source and destination step up, down or stay, each by own setting.
// - Normal mode may interrupt the CPU when its count ends.
// - Repeat mode moves one unit; area select picks repeat side.
// - Repeat end restores counter and repeat-side pointer; other pointer updates.
// - Repeat low count reloads from stored high byte; high byte unchanged.
// - Repeat mode with interrupt select 0 never interrupts the CPU.
// - When low count is 1, repeat-side pointer written back at initial value.
// - Block mode moves one whole block; area select picks block side.
// - After each block, reload block counter and restore block-side pointer.
// - Block mode decrements count B per block; interrupt at its end.
// - Chain enable runs the next descriptor in the same activation.
// - With chain-on-zero also set, chain only when the counter reached zero.
// - Every chained descriptor carries its own pointers, counts and modes.
// - Chained transfers raise no interrupt and clear neither source nor enable.
// - Repeat chain enable chains after the transfer made with counter 1.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module dxm_engine (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_sys_rst,
   input  wire logic                          i_clk_en,
   // Activation from the interrupt source side
   input  wire logic                          i_act_req,
   input  wire logic [31:0]                   i_act_desc_addr,
   output var  logic                          o_busy,
   output var  dxm_pkg::dxm_evt_s             o_evt,
   // Internal bus master
   output var  dxm_pkg::dxm_bus_s             o_bus,
   input  wire logic                          i_bus_ack,
   input  wire logic [31:0]                   i_bus_rdata,
   // Software register port
   input  wire logic [dxm_pkg::REG_AW-1:0]    i_reg_addr,
   input  wire logic [31:0]                   i_reg_wdata,
   input  wire logic                          i_reg_wr,
   input  wire logic                          i_reg_rd,
   output var  logic [31:0]                   o_reg_rdata
);

   // Unit step along a pointer by the selected update code and size
   function automatic logic [31:0] step_ptr(input logic [31:0] ptr,
                                            input logic [1:0]  upd,
                                            input logic [1:0]  size);
      logic [31:0] inc;
      inc = (size == dxm_pkg::SZ_LONG) ? 32'h00000004 :
            (size == dxm_pkg::SZ_WORD) ? 32'h00000002 : 32'h00000001;
      if (upd == dxm_pkg::UPD_INC) begin
         step_ptr = ptr + inc;
      end else if (upd == dxm_pkg::UPD_DEC) begin
         step_ptr = ptr - inc;
      end else begin
         step_ptr = ptr;
      end
   endfunction

   dxm_pkg::dxm_state_e state_q, state_d;
   logic [31:0] words_q [0:3];
   logic [1:0]  widx_q;
   logic [31:0] desc_addr_q;
   logic        fmt_full_q;
   logic [7:0]  mode_a_q, mode_b_q;
   logic [31:0] src_q, dst_q, src_init_q, dst_init_q, data_q;
   logic [15:0] cnt_a_q, cnt_b_q;
   logic [7:0]  blk_q;
   logic        chain_go_q, irq_q, en_clr_q;
   logic [1:0]  ctrl_q;
   logic [15:0] done_cnt_q;
   dxm_pkg::dxm_bus_s bus_d;

   // Mode field decode of the working descriptor
   wire [1:0] mode      = mode_a_q[dxm_pkg::MA_MD_HI:dxm_pkg::MA_MD_LO];
   wire [1:0] unit_sz   = mode_a_q[dxm_pkg::MA_SZ_HI:dxm_pkg::MA_SZ_LO];
   wire [1:0] src_upd   = mode_a_q[dxm_pkg::MA_SU_HI:dxm_pkg::MA_SU_LO];
   wire [1:0] dst_upd   = mode_b_q[dxm_pkg::MB_DU_HI:dxm_pkg::MB_DU_LO];
   wire       chain_en  = mode_b_q[dxm_pkg::MB_CHAIN];
   wire       chain_z   = mode_b_q[dxm_pkg::MB_CHAIN_ZERO];
   wire       irq_sel   = mode_b_q[dxm_pkg::MB_IRQ_SEL];
   wire       area_src  = mode_b_q[dxm_pkg::MB_AREA];
   wire       is_normal = (mode == dxm_pkg::MD_NORMAL);
   wire       is_repeat = (mode == dxm_pkg::MD_REPEAT);
   wire       is_block  = (mode == dxm_pkg::MD_BLOCK);
   wire [7:0] cnt_hi    = cnt_a_q[15:8];
   wire [7:0] cnt_lo    = cnt_a_q[7:0];

   // Descriptor geometry follows the format latched at activation
   wire [1:0]  last_idx   = fmt_full_q ? dxm_pkg::FULL_LAST : dxm_pkg::SHORT_LAST;
   wire [31:0] desc_bytes = fmt_full_q ? dxm_pkg::FULL_BYTES : dxm_pkg::SHORT_BYTES;
   wire        at_last    = (widx_q == last_idx);
   wire        bus_done   = o_bus.req & i_bus_ack;
   wire [31:0] word_addr  = desc_addr_q + {28'h0000000, widx_q, 2'b00};

   // own fields per descriptor
   // Parsing of the freshly read words; short format packs 24-bit pointers with modes
   wire [7:0]  ld_mode_a = words_q[0][31:24];
   wire [7:0]  ld_mode_b = fmt_full_q ? words_q[0][23:16] : words_q[1][31:24];
   wire [31:0] ld_src    = fmt_full_q ? words_q[1] : {8'h00, words_q[0][23:0]};
   wire [31:0] ld_dst    = fmt_full_q ? words_q[2] : {8'h00, words_q[1][23:0]};
   wire [31:0] ld_cnts   = fmt_full_q ? words_q[3] : words_q[2];

   // End-of-transfer decisions, evaluated in ST_UPD before counts change
   // repeat count never ends
   wire end_zero = is_normal ? (cnt_a_q == 16'h0001) :
                   is_block  ? (cnt_b_q == 16'h0001) : 1'b0;
   wire chain_zero = is_repeat ? (ctrl_q[dxm_pkg::CTRL_RCHAIN] & (cnt_lo == 8'h01))
                               : end_zero;
   wire chain_go   = chain_en & (~chain_z | chain_zero);
   wire irq_go     = ~chain_en & (end_zero | irq_sel);
   wire restore    = is_block | (is_repeat & (cnt_lo == 8'h01));
   wire [7:0]  rep_n    = is_repeat ? (cnt_hi - 8'h01) : 8'h00;
   wire [31:0] src_home = src_init_q - 32'(step_ptr(32'h0, src_upd, unit_sz) * rep_n);
   wire [31:0] dst_home = dst_init_q - 32'(step_ptr(32'h0, dst_upd, unit_sz) * rep_n);

   wire [15:0] cnt_a_n = is_normal ? (cnt_a_q - 16'h0001) :
                         is_repeat ? ((cnt_lo == 8'h01) ? {cnt_hi, cnt_hi}
                                                        : {cnt_hi, cnt_lo - 8'h01}) :
                                     {cnt_hi, cnt_hi};
   wire [15:0] cnt_b_n = is_block ? (cnt_b_q - 16'h0001) : cnt_b_q;

   // Writeback images of each descriptor word
   wire [31:0] wb_word0 = {mode_a_q, src_q[23:0]};
   wire [31:0] wb_word1 = fmt_full_q ? src_q : {mode_b_q, dst_q[23:0]};
   wire [31:0] wb_word2 = fmt_full_q ? dst_q : {cnt_a_q, cnt_b_q};
   wire [31:0] wb_word3 = {cnt_a_q, cnt_b_q};
   wire [31:0] wb_data  = (widx_q == 2'h0) ? wb_word0 :
                          (widx_q == 2'h1) ? wb_word1 :
                          (widx_q == 2'h2) ? wb_word2 : wb_word3;
   wire src_wb = src_upd[1];
   wire dst_wb = dst_upd[1];
   wire [3:0] wb_mask = fmt_full_q ? {1'b1, dst_wb, src_wb, 1'b0}
                                   : {1'b0, 1'b1, dst_wb, src_wb};
   wire wb_need = wb_mask[widx_q];
   wire wb_step = (state_q == dxm_pkg::ST_WBACK) & (~wb_need | bus_done);

   // Bus request wanted in the current state
   wire want_rd_desc = (state_q == dxm_pkg::ST_DESC_RD);
   wire want_rd_data = (state_q == dxm_pkg::ST_DATA_RD);
   wire want_wr_data = (state_q == dxm_pkg::ST_DATA_WR);
   wire want_wb      = (state_q == dxm_pkg::ST_WBACK) & wb_need;
   wire want_bus     = want_rd_desc | want_rd_data | want_wr_data | want_wb;
   wire take_act     = i_act_req & (state_q == dxm_pkg::ST_IDLE);

   // Next bus request; a one-cycle gap follows each acknowledge
   always_comb begin
      bus_d       = dxm_pkg::BUS_IDLE;
      bus_d.req   = want_bus & ~bus_done;
      bus_d.we    = want_wr_data | want_wb;
      bus_d.size  = (want_rd_data | want_wr_data) ? unit_sz : dxm_pkg::SZ_LONG;
      bus_d.addr  = want_rd_data ? src_q : want_wr_data ? dst_q : word_addr;
      bus_d.wdata = want_wr_data ? data_q : wb_data;
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         dxm_pkg::ST_IDLE:    if (take_act) begin
            state_d = dxm_pkg::ST_DESC_RD;
         end
         dxm_pkg::ST_DESC_RD: if (bus_done & at_last) begin
            state_d = dxm_pkg::ST_LOAD;
         end
         dxm_pkg::ST_LOAD:    state_d = dxm_pkg::ST_DATA_RD;
         dxm_pkg::ST_DATA_RD: if (bus_done) begin
            state_d = dxm_pkg::ST_DATA_WR;
         end
         // block loops until its last unit
         dxm_pkg::ST_DATA_WR: if (bus_done) begin
            state_d = (is_block & (blk_q != 8'h01)) ? dxm_pkg::ST_DATA_RD
                                                    : dxm_pkg::ST_UPD;
         end
         dxm_pkg::ST_UPD:     state_d = dxm_pkg::ST_WBACK;
         dxm_pkg::ST_WBACK:   if (wb_step & at_last) begin
            state_d = chain_go_q ? dxm_pkg::ST_DESC_RD : dxm_pkg::ST_DONE;
         end
         dxm_pkg::ST_DONE:    state_d = dxm_pkg::ST_IDLE;
         default:             state_d = dxm_pkg::ST_IDLE;
      endcase
   end

   // State, bus and busy flops
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= dxm_pkg::ST_IDLE;
         o_bus   <= dxm_pkg::BUS_IDLE;
         o_busy  <= 1'b0;
      end else if (i_clk_en) begin
         state_q <= state_d;
         o_bus   <= bus_d;
         o_busy  <= (state_d != dxm_pkg::ST_IDLE);
      end
   end

   // Descriptor word index and base address
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         widx_q      <= 2'h0;
         desc_addr_q <= 32'h00000000;
         fmt_full_q  <= 1'b0;
      end else if (i_clk_en) begin
         if (take_act) begin
            desc_addr_q <= i_act_desc_addr;
            fmt_full_q  <= ctrl_q[dxm_pkg::CTRL_FULL];
            widx_q      <= 2'h0;
         end else if ((want_rd_desc & bus_done) | wb_step) begin
            widx_q <= at_last ? 2'h0 : widx_q + 2'h1;
            // next descriptor follows the current one
            if (wb_step & at_last & chain_go_q) begin
               desc_addr_q <= desc_addr_q + desc_bytes;
            end
         end
      end
   end

   // Raw descriptor words, stored by index as they arrive
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            words_q[i] <= 32'h00000000;
         end
      end else if (i_clk_en & want_rd_desc & bus_done) begin
         words_q[widx_q] <= i_bus_rdata;
      end
   end

   // Working descriptor: modes and counts
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_a_q <= 8'h00;
         mode_b_q <= 8'h00;
         cnt_a_q  <= 16'h0000;
         cnt_b_q  <= 16'h0000;
         blk_q    <= 8'h00;
      end else if (i_clk_en) begin
         if (state_q == dxm_pkg::ST_LOAD) begin
            mode_a_q <= ld_mode_a;
            mode_b_q <= ld_mode_b;
            cnt_a_q  <= ld_cnts[31:16];
            cnt_b_q  <= ld_cnts[15:0];
            blk_q    <= ld_cnts[23:16];   // Block size comes from the low count byte
         end else if (want_wr_data & bus_done & is_block) begin
            blk_q <= blk_q - 8'h01;       // Zero start wraps, giving 256 units
         end else if (state_q == dxm_pkg::ST_UPD) begin
            cnt_a_q <= cnt_a_n;
            cnt_b_q <= cnt_b_n;
         end
      end
   end

   // Pointers: step per unit, then restore the area side
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         src_q      <= 32'h00000000;
         dst_q      <= 32'h00000000;
         src_init_q <= 32'h00000000;
         dst_init_q <= 32'h00000000;
         data_q     <= 32'h00000000;
      end else if (i_clk_en) begin
         if (state_q == dxm_pkg::ST_LOAD) begin
            src_q      <= ld_src;
            dst_q      <= ld_dst;
            src_init_q <= ld_src;
            dst_init_q <= ld_dst;
         end else if (want_rd_data & bus_done) begin
            data_q <= i_bus_rdata;
         end else if (want_wr_data & bus_done) begin
            src_q <= step_ptr(src_q, src_upd, unit_sz);
            dst_q <= step_ptr(dst_q, dst_upd, unit_sz);
         end else if ((state_q == dxm_pkg::ST_UPD) & restore) begin
            if (area_src) begin
               src_q <= src_home;
            end else begin
               dst_q <= dst_home;
            end
         end
      end
   end

   // End flags of the last transfer, kept for writeback and completion
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         chain_go_q <= 1'b0;
         irq_q      <= 1'b0;
         en_clr_q   <= 1'b0;
      end else if (i_clk_en & (state_q == dxm_pkg::ST_UPD)) begin
         chain_go_q <= chain_go;
         irq_q      <= irq_go;
         en_clr_q   <= ~chain_en & end_zero;
      end
   end

   // one-cycle completion events after final writeback
   // chained descriptors never reach ST_DONE, so they raise nothing
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_evt <= dxm_pkg::EVT_NONE;
      end else if (i_clk_en) begin
         o_evt.irq       <= (state_q == dxm_pkg::ST_DONE) & irq_q;
         o_evt.src_clear <= (state_q == dxm_pkg::ST_DONE) & ~irq_q;
         o_evt.en_clear  <= (state_q == dxm_pkg::ST_DONE) & en_clr_q;
      end
   end

   // Register read decode; unmapped offsets read as zero
   wire [31:0] rd_mux =
      (i_reg_addr == dxm_pkg::REG_CTRL)   ? {30'h00000000, ctrl_q} :
      (i_reg_addr == dxm_pkg::REG_STATUS) ? {28'h0000000, state_q, o_busy} :
      (i_reg_addr == dxm_pkg::REG_DESC)   ? desc_addr_q :
      (i_reg_addr == dxm_pkg::REG_COUNT)  ? {16'h0000, done_cnt_q} : 32'h00000000;
   wire ctrl_wr = i_reg_wr & (i_reg_addr == dxm_pkg::REG_CTRL);

   // Control register and activation counter; format change applies at next activation
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q      <= dxm_pkg::CTRL_RST;
         done_cnt_q  <= 16'h0000;
         o_reg_rdata <= 32'h00000000;
      end else if (i_clk_en) begin
         if (ctrl_wr) begin
            ctrl_q <= i_reg_wdata[1:0];
         end
         if (state_q == dxm_pkg::ST_DONE) begin
            done_cnt_q <= done_cnt_q + 16'h0001;
         end
         o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
      end
   end

endmodule

`default_nettype wire

/* File: dxm_engine_props.sv */
// Port checks for the transfer engine: bus handshake, activation and end events.
// Assumes one clock domain; bound onto every dxm_engine instance.
`timescale 1ns/100ps
`default_nettype none
module dxm_engine_props (
   input wire logic              i_sys_clk,
   input wire logic              i_sys_rst,
   input wire logic              i_clk_en,
   input wire logic              i_act_req,
   input wire logic              o_busy,
   input wire dxm_pkg::dxm_evt_s o_evt,
   input wire dxm_pkg::dxm_bus_s o_bus,
   input wire logic              i_bus_ack
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   // End events are single pulses that coincide with the return to idle
   evt_pulse_a: assert property (o_evt != '0 && i_clk_en |=> o_evt == '0)
      else $error("end event longer than one cycle");
   evt_idle_a: assert property (o_evt != '0 |-> !o_busy && $past(o_busy))
      else $error("end event not at the busy fall");
   evt_kind_a: assert property (o_evt != '0 |-> o_evt.irq != o_evt.src_clear)
      else $error("end event neither or both of irq and source clear");
   end_irq_a: assert property (o_evt.en_clear |-> o_evt.irq)
      else $error("count end without interrupt");
   // A request must hold still until taken, and drop right after
   req_hold_a: assert property (o_bus.req && !i_bus_ack |=> o_bus.req && $stable(o_bus))
      else $error("bus request changed before acknowledge");
   req_drop_a: assert property (o_bus.req && i_bus_ack && i_clk_en |=> !o_bus.req)
      else $error("bus request held after acknowledge");
   // Activation accepted whenever idle, and bounded in length
   act_take_a: assert property (i_act_req && !o_busy && i_clk_en |=> o_busy)
      else $error("idle activation not taken");
   idle_bus_a: assert property (!o_busy |-> !o_bus.req)
      else $error("bus request while idle");
   busy_end_a: assert property ($rose(o_busy) |-> ##[1:1000] !o_busy)
      else $error("activation did not complete");
endmodule
bind dxm_engine dxm_engine_props dxm_engine_props_inst (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_act_req(i_act_req),
   .o_busy(o_busy), .o_evt(o_evt), .o_bus(o_bus), .i_bus_ack(i_bus_ack));
`default_nettype wire

/* File: dxm_mem_model.sv */
// Memory on the engine's internal bus: 256 words, byte, word and long access.
// Assumes one request at a time; acks after 1 cycle, or 3 with i_slow high.
`timescale 1ns/100ps
`default_nettype none
module dxm_mem_model (
   input  wire logic              i_sys_clk,
   input  wire dxm_pkg::dxm_bus_s i_bus,
   input  wire logic              i_slow,
   output var  logic              o_ack,
   output var  logic [31:0]       o_rdata
);
   logic [31:0] mem [0:255];
   logic [1:0]  wait_q = 2'h0;
   wire  [7:0]  widx = i_bus.addr[9:2];
   wire  [4:0]  sh   = {i_bus.addr[1:0], 3'h0};
   initial o_ack = 1'b0;
   initial o_rdata = 32'h0;
   // Read data toggles outside the ack so a stale value never passes for an answer
   always @(posedge i_sys_clk) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_bus.req && !o_ack && i_slow && wait_q != 2'h2) begin
         wait_q <= wait_q + 2'h1;
      end else if (i_bus.req && !o_ack) begin
         wait_q <= 2'h0;
         o_ack  <= 1'b1;
         if (!i_bus.we) o_rdata <= mem[widx] >> sh;
         else if (i_bus.size == dxm_pkg::SZ_BYTE) mem[widx][sh +: 8] <= i_bus.wdata[7:0];
         else if (i_bus.size == dxm_pkg::SZ_WORD) mem[widx][sh +: 16] <= i_bus.wdata[15:0];
         else mem[widx] <= i_bus.wdata;
      end
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench for the transfer engine: table of single transfers, then full format,
// chains, clock enable and reset. Assumes dxm_mem_model as the bus slave.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct {
      logic [7:0]  ma, mb;
      logic [23:0] src, dst;
      logic [15:0] ca, cb;
      logic [23:0] e_src, e_dst;
      logic [15:0] e_ca, e_cb;
      logic [2:0]  e_evt;
      logic [7:0]  e_da;
      logic [31:0] e_dat;
      logic [3:0]  e_wr;
   } dxm_row_s;
   logic              clk, rst, en, act, r_wr, r_rd, ack, busy, slow;
   logic [31:0]       act_addr, rdata, r_wdata, r_data, rd;
   logic [3:0]        r_addr;
   dxm_pkg::dxm_evt_s evt, ev;
   dxm_pkg::dxm_bus_s bus;
   int                bad_count, n_tests, wr_cnt, evt_cnt, w0, e0;
   // Inputs; then expected pointers, counts, event, data word, writes
   dxm_row_s rows [6] = '{
      '{8'h28, 8'h08, 24'h200, 24'h300, 16'h5, 16'h7,
        24'h204, 24'h304, 16'h4, 16'h7, 3'h2, 8'hC0, 32'h11223380, 4'h4},
      '{8'h0C, 8'h00, 24'h201, 24'h301, 16'h1, 16'h7,
        24'h200, 24'h301, 16'h0, 16'h7, 3'h5, 8'hC0, 32'h00003300, 4'h3},
      '{8'h58, 8'h08, 24'h200, 24'h300, 16'h301, 16'h7,
        24'h202, 24'h2FC, 16'h303, 16'h7, 3'h2, 8'hC0, 32'h00003380, 4'h4},
      '{8'h58, 8'h28, 24'h200, 24'h300, 16'h302, 16'h7,
        24'h202, 24'h302, 16'h301, 16'h7, 3'h4, 8'hC0, 32'h00003380, 4'h4},
      '{8'hA8, 8'h18, 24'h200, 24'h300, 16'h202, 16'h1,
        24'h200, 24'h308, 16'h202, 16'h0, 3'h5, 8'hC1, 32'h11223381, 4'h5},
      '{8'h20, 8'h0C, 24'h204, 24'h304, 16'h0, 16'h7,
        24'h204, 24'h300, 16'hFFFF, 16'h7, 3'h2, 8'hC1, 32'h11223381, 4'h3}};
   // Chain cases: modes, count, expected second count, expected irq
   logic [48:0] ch [4] = '{{8'h28, 8'h88, 16'h5, 16'h0, 1'b1}, {8'h28, 8'hC8, 16'h5, 16'h1, 1'b0},
                           {8'h28, 8'hC8, 16'h1, 16'h0, 1'b1}, {8'h68, 8'hC8, 16'h301, 16'h0, 1'b1}};
   dxm_engine dxm_engine_inst (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_act_req(act),
      .i_act_desc_addr(act_addr), .o_busy(busy), .o_evt(evt), .o_bus(bus),
      .i_bus_ack(ack), .i_bus_rdata(rdata), .i_reg_addr(r_addr), .i_reg_wdata(r_wdata),
      .i_reg_wr(r_wr), .i_reg_rd(r_rd), .o_reg_rdata(r_data));
   dxm_mem_model dxm_mem_model_inst (
      .i_sys_clk(clk), .i_bus(bus), .i_slow(slow), .o_ack(ack), .o_rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Count taken bus writes and end pulses
   always @(posedge clk) begin
      if (bus.req && bus.we && ack && en) wr_cnt <= wr_cnt + 1;
      if (evt != '0) evt_cnt <= evt_cnt + 1;
   end
   task automatic tally_and_finish;
      if (bad_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_evt(input dxm_pkg::dxm_evt_s got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t event got %b exp %b", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] mr(input logic [7:0] i);
      return dxm_mem_model_inst.mem[i];
   endfunction
   // Short descriptor at word i, plus fresh source pattern and cleared destination
   task automatic load_short(input logic [7:0] i, ma, mb, input logic [23:0] s, d,
                             input logic [15:0] ca, cb);
      dxm_mem_model_inst.mem[i] = {ma, s};
      dxm_mem_model_inst.mem[i + 8'h1] = {mb, d};
      dxm_mem_model_inst.mem[i + 8'h2] = {ca, cb};
      for (int j = 0; j < 4; j++) begin
         dxm_mem_model_inst.mem[8'h80 + j] = 32'h11223380 + j;
         dxm_mem_model_inst.mem[8'hC0 + j] = 32'h0;
      end
   endtask
   task automatic load_row(input int r);
      load_short(8'h40, rows[r].ma, rows[r].mb, rows[r].src, rows[r].dst, rows[r].ca, rows[r].cb);
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      r_wr    <= 1'b1;
      r_addr  <= a;
      r_wdata <= d;
      @(posedge clk);
      r_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      r_rd   <= 1'b1;
      r_addr <= a;
      @(posedge clk);
      r_rd <= 1'b0;
      @(negedge clk);
      d = r_data;
   endtask
   // One-cycle activation pulse, then a bounded wait for the end event
   task automatic run_act;
      int k;
      k = 0;
      w0 = wr_cnt;
      @(posedge clk);
      act <= 1'b1;
      @(posedge clk);
      act <= 1'b0;
      while (evt === '0 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      ev = evt;
      if (k == 2000) begin
         bad_count++;
         $display("BAD %0t activation never ended", $time);
         tally_and_finish();
      end
   endtask
   initial begin
      rst = 1'b1;
      en = 1'b1;
      act = 1'b0;
      act_addr = 32'h100;
      {r_wr, r_rd, slow, r_addr, r_wdata} = '0;
      {bad_count, n_tests, wr_cnt, evt_cnt} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reg_rd(4'h4, rd);
      chk_word(rd, 32'h0);
      reg_rd(4'h2, rd);
      chk_word(rd, 32'h0);
      for (int r = 0; r < 6; r++) begin
         load_row(r);
         run_act();
         chk_evt(ev, rows[r].e_evt);
         chk_word(mr(8'h40), {rows[r].ma, rows[r].e_src});
         chk_word(mr(8'h41), {rows[r].mb, rows[r].e_dst});
         chk_word(mr(8'h42), {rows[r].e_ca, rows[r].e_cb});
         chk_word(mr(rows[r].e_da), rows[r].e_dat);
         chk_word(32'(wr_cnt - w0), 32'(rows[r].e_wr));
      end
      // Full format: mode word, then src, dst, counts; fixed pointers both skipped
      reg_wr(4'h0, 32'h3);
      reg_rd(4'h0, rd);
      chk_word(rd, 32'h3);
      load_short(8'h40, 8'h20, 8'h00, 24'h00A5A5, 24'h000204, 16'h0, 16'h0304);
      dxm_mem_model_inst.mem[8'h43] = 32'h00030007;
      run_act();
      chk_word(mr(8'h40), 32'h2000A5A5);
      chk_word(mr(8'h43), 32'h00020007);
      chk_word(32'(wr_cnt - w0), 32'h2);
      // Chains against a slow memory, second descriptor twelve bytes on
      reg_wr(4'h0, 32'h1);
      slow <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         load_short(8'h40, ch[c][48:41], ch[c][40:33], 24'h200, 24'h300, ch[c][32:17], 16'h7);
         load_short(8'h43, 8'h20, 8'h00, 24'h208, 24'h308, 16'h1, 16'h7);
         e0 = evt_cnt;
         run_act();
         repeat (3) @(negedge clk);
         chk_word({31'h0, ev.irq}, {31'h0, ch[c][0]});
         chk_word(mr(8'h45), {ch[c][16:1], 16'h7});
         chk_word(32'(evt_cnt - e0), 32'h1);
      end
      // Frozen engine must not take an activation
      @(posedge clk);
      en  <= 1'b0;
      act <= 1'b1;
      @(posedge clk);
      act <= 1'b0;
      @(posedge clk);
      en <= 1'b1;
      @(negedge clk);
      chk_word({31'h0, busy}, 32'h0);
      reg_rd(4'hC, rd);
      chk_word(rd, 32'hB);
      // Reset in mid-transfer, then a clean rerun
      load_row(0);
      @(posedge clk);
      act <= 1'b1;
      @(posedge clk);
      act <= 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b1;
      @(negedge clk);
      chk_word({30'h0, busy, bus.req}, 32'h0);
      @(posedge clk);
      rst <= 1'b0;
      load_row(0);
      run_act();
      chk_evt(ev, 3'h2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
